// File: pkg/decision_engine_defs.svh
// Constants for the decision engine: addresses, fields and reset values
`ifndef DECISION_ENGINE_DEFS_SVH
`define DECISION_ENGINE_DEFS_SVH
`define DE_PROC_ADDR 4'h2
`define DE_OFS_STATUS 12'h000
`define DE_OFS_PC 12'h001
`define DE_PMEM_BIT 11
`define DE_FIELD0_MASK 16'hCE7F
`define DE_FIELD1_MASK 16'hFFFF
`define DE_ST_DONE_BIT 15
`define DE_ST_RESULT_BIT 14
`define DE_EN_HI_BIT 15
`define DE_EN_LO_BIT 14
`define DE_ENABLE_RESET 16'h0000
`define DE_PC_RESET 10'h000
`define DE_ZERO16 16'h0000
`endif

// File: pkg/decision_engine_pkg.sv
// Types for the decision engine
package decision_engine_pkg;
  typedef enum logic [1:0] {ST_FETCH, ST_EXEC, ST_PAUSE} engine_state_t;
  typedef enum logic [1:0] {CLS_LOADSTORE, CLS_CMP, CLS_CMM, CLS_IMM} op_class_t;
  typedef logic [15:0] word16_t;
endpackage

// File: core/decision_engine.sv
// Decision engine: register files, program store, status and system bus
// Operation
// - Two 128-word register files, worked on by compare and modify steps.
// - Index file has a read port for the neighbouring address processor.
// - Index port is independent, so both processors reach it overlapped.
// - Control processor writes to enable and program counter are accepted.
// - Bus accesses are taken only when processor address two is selected.
// - Enable register is write-only; reads never return its contents.
// - Status word and enable register share one address.
// - Program store holds 1,024 words addressed by the program counter.
// - Each program word is 32 bits in two 16-bit fields.
// - Each field has its own address and is read or written alone.
// - Unused instruction bits ignore writes and read back as zero.
// - Decoder sorts words into four instruction categories.
// - Compare and immediate loads stand alone with the pause portion.
// - Load/store may pair with a load/store second half or a move.
// - Conditional forms pair the same way as the plain forms.
`timescale 1ns/1ps
`include "decision_engine_defs.svh"
module decision_engine #(
  parameter int FILE_DEPTH = 128,
  parameter int PMEM_DEPTH = 1024
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic runMode,
  input wire logic busSel,
  input wire logic [3:0] busProcAddr,
  input wire logic [11:0] busRegAddr,
  input wire logic busWrite,
  input wire logic busRead,
  input wire decision_engine_pkg::word16_t busWrData,
  output decision_engine_pkg::word16_t busRdData,
  output logic busRdValid,
  input wire decision_engine_pkg::word16_t dataMemIn,
  input wire logic [6:0] idxAddr,
  output decision_engine_pkg::word16_t idxData,
  output logic [9:0] pcOut,
  output logic engineHalted,
  output logic illegalWord
);
  import decision_engine_pkg::*;

  word16_t xFile [FILE_DEPTH];
  word16_t iFile [FILE_DEPTH];
  word16_t progField0 [PMEM_DEPTH];
  word16_t progField1 [PMEM_DEPTH];

  engine_state_t state_reg;
  logic [9:0] pc_reg;
  word16_t enable_reg, instr0_reg, instr1_reg, temp_reg;
  logic done_reg, result_reg, illegal_reg;
  logic [2:0] pause_reg;

  logic busHit, pmemAcc, wrStatus, wrPc, rdStatus, pmemField;
  logic haltNow, engineGo, condForm, firstOk, secondIsMove, secondOk;
  logic wordLegal, condPass, compareHit, doCompare;
  logic [9:0] pmemWord;
  op_class_t opClass;
  logic [3:0] firstOp, secondOp;
  logic [6:0] regA, regB;

  assign busHit = busSel && (busProcAddr == `DE_PROC_ADDR);
  assign pmemAcc = busRegAddr[`DE_PMEM_BIT];
  assign pmemWord = busRegAddr[10:1];
  assign pmemField = busRegAddr[0];
  assign wrStatus = busHit && busWrite && !pmemAcc
    && (busRegAddr == `DE_OFS_STATUS);
  assign rdStatus = busHit && busRead && !pmemAcc
    && (busRegAddr == `DE_OFS_STATUS);
  assign wrPc = busHit && busWrite && !pmemAcc
    && (busRegAddr == `DE_OFS_PC);

  // Enable bits stop the engine on the chosen compare outcome
  assign haltNow = (enable_reg[`DE_EN_HI_BIT] && result_reg)
    || (enable_reg[`DE_EN_LO_BIT] && !result_reg);
  assign engineGo = runMode && !haltNow;
  assign engineHalted = runMode && haltNow;
  assign pcOut = pc_reg;
  assign illegalWord = illegal_reg;

  // Field layout: field 0 holds class, pause count and first register
  assign opClass = op_class_t'(instr0_reg[15:14]);
  assign regA = instr0_reg[6:0];
  assign firstOp = instr1_reg[15:12];
  assign secondOp = instr1_reg[11:8];
  assign condForm = instr1_reg[7];
  assign regB = instr1_reg[6:0];

  always_comb
  begin
    firstOk = 1'b0;
    secondOk = 1'b0;
    secondIsMove = 1'b0;
    case (firstOp)
      4'h0, 4'hD, 4'hF, 4'hE, 4'h7, 4'hB: firstOk = 1'b1;
      default: firstOk = 1'b0;
    endcase
    case (secondOp)
      4'h0, 4'hD, 4'hF, 4'hE, 4'h7, 4'hB: secondOk = 1'b1;
      4'h5, 4'h9, 4'h3, 4'hA:
      begin
        secondOk = 1'b1;
        secondIsMove = 1'b1;
      end
      default: secondOk = 1'b0;
    endcase
  end

  // Compare and immediate words carry no second operation of their own
  assign wordLegal = (opClass != CLS_LOADSTORE) ? 1'b1
    : (firstOk && secondOk
       && !(firstOp == 4'h0 && secondOp != 4'h0));
  // One flag covers both halves, so conditional halves never mix
  assign condPass = !condForm || result_reg;
  assign compareHit = dataMemIn <= xFile[regA];
  assign doCompare = (state_reg == ST_EXEC)
    && (opClass == CLS_CMP || opClass == CLS_CMM);

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state_reg <= ST_FETCH;
      pc_reg <= `DE_PC_RESET;
      instr0_reg <= `DE_ZERO16;
      instr1_reg <= `DE_ZERO16;
      pause_reg <= 3'h0;
      illegal_reg <= 1'b0;
    end
    else if (wrPc)
    begin
      pc_reg <= busWrData[9:0];
      state_reg <= ST_FETCH;
      pause_reg <= 3'h0;
    end
    else if (engineGo)
    begin
      case (state_reg)
        ST_FETCH:
        begin
          instr0_reg <= progField0[pc_reg];
          instr1_reg <= progField1[pc_reg];
          state_reg <= ST_EXEC;
        end
        ST_EXEC:
        begin
          illegal_reg <= !wordLegal;
          pause_reg <= instr0_reg[11:9];
          if (instr0_reg[11:9] == 3'h0)
          begin
            pc_reg <= pc_reg + 10'h001;
            state_reg <= ST_FETCH;
          end
          else
          begin
            state_reg <= ST_PAUSE;
          end
        end
        ST_PAUSE:
        begin
          pause_reg <= pause_reg - 3'h1;
          if (pause_reg == 3'h1)
          begin
            pc_reg <= pc_reg + 10'h001;
            state_reg <= ST_FETCH;
          end
        end
        default: state_reg <= ST_FETCH;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      enable_reg <= `DE_ENABLE_RESET;
    end
    else if (wrStatus)
    begin
      enable_reg <= busWrData;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      done_reg <= 1'b0;
      result_reg <= 1'b0;
    end
    else
    begin
      if (doCompare && engineGo)
      begin
        done_reg <= 1'b1;
        result_reg <= compareHit;
      end
      else if (rdStatus)
      begin
        done_reg <= 1'b0;
      end
    end
  end

  // Execution on the register files; illegal words do nothing
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      temp_reg <= `DE_ZERO16;
    end
    else if (engineGo && state_reg == ST_EXEC)
    begin
      case (opClass)
        CLS_CMM:
        begin
          if (compareHit)
          begin
            xFile[regA] <= xFile[regA] + instr1_reg;
          end
        end
        CLS_IMM:
        begin
          case (instr0_reg[1:0])
            2'h3: temp_reg <= instr1_reg;
            2'h2: xFile[regA] <= instr1_reg;
            2'h1: iFile[regA] <= instr1_reg;
            default: temp_reg <= temp_reg;
          endcase
        end
        CLS_LOADSTORE:
        begin
          if (wordLegal && condPass)
          begin
            case (firstOp)
              4'hD: temp_reg <= iFile[regA];
              4'hE: temp_reg <= xFile[regA];
              4'hF: temp_reg <= {15'h0000, result_reg};
              4'h7: iFile[regA] <= temp_reg;
              4'hB: xFile[regA] <= temp_reg;
              default: temp_reg <= temp_reg;
            endcase
            // Move reads the register that the first half names
            if (secondIsMove)
            begin
              case (secondOp)
                4'h5: iFile[regB] <= iFile[regA];
                4'h9: xFile[regB] <= iFile[regA];
                4'h3: iFile[regB] <= xFile[regA];
                default: xFile[regB] <= xFile[regA];
              endcase
            end
            else
            begin
              case (secondOp)
                4'h7: iFile[regB] <= temp_reg;
                4'hB: xFile[regB] <= temp_reg;
                default: temp_reg <= temp_reg;
              endcase
            end
          end
        end
        default: temp_reg <= temp_reg;
      endcase
    end
  end

  // Host program loads; unused field bits are dropped on the way in
  always_ff @(posedge clk)
  begin
    if (busHit && busWrite && pmemAcc)
    begin
      if (pmemField)
      begin
        progField1[pmemWord] <= busWrData & `DE_FIELD1_MASK;
      end
      else
      begin
        progField0[pmemWord] <= busWrData & `DE_FIELD0_MASK;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      busRdData <= `DE_ZERO16;
      busRdValid <= 1'b0;
    end
    else
    begin
      busRdValid <= busHit && busRead;
      if (busHit && busRead)
      begin
        if (pmemAcc)
        begin
          busRdData <= pmemField ? progField1[pmemWord]
            : (progField0[pmemWord] & `DE_FIELD0_MASK);
        end
        else if (busRegAddr == `DE_OFS_STATUS)
        begin
          busRdData <= {done_reg, result_reg, 11'h000, pause_reg};
        end
        else if (busRegAddr == `DE_OFS_PC)
        begin
          busRdData <= {6'h00, pc_reg};
        end
        else
        begin
          busRdData <= `DE_ZERO16;
        end
      end
    end
  end

  // Separate read port: the address processor never waits on the engine
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      idxData <= `DE_ZERO16;
    end
    else
    begin
      idxData <= iFile[idxAddr];
    end
  end

endmodule // decision_engine

// File: verification/decision_engine_monitor.sv
// Assertion checker for the decision engine bus side
`timescale 1ns/1ps
module decision_engine_monitor
  import decision_engine_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic runMode,
  input wire logic busSel,
  input wire logic [3:0] busProcAddr,
  input wire logic [11:0] busRegAddr,
  input wire logic busWrite,
  input wire logic busRead,
  input wire decision_engine_pkg::word16_t busWrData,
  input wire decision_engine_pkg::word16_t busRdData,
  input wire logic busRdValid,
  input wire logic [9:0] pcOut,
  input wire logic engineHalted
);
  logic hit;
  assign hit = busSel && busProcAddr == 4'h2;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_statRd;
    hit && busRead && busRegAddr == 12'h000;
  endsequence
  chk_read_answer: assert property (hit && busRead |=> busRdValid)
    else $error("Read not answered");
  chk_foreign_silent: assert property (
    !(hit && busRead) |=> !busRdValid)
    else $error("Unselected read answered");
  chk_data_held: assert property (
    !busRdValid |-> $stable(busRdData))
    else $error("Read data moved");
  chk_pc_write: assert property (
    hit && busWrite && busRegAddr == 12'h001
    |=> pcOut == $past(busWrData[9:0]))
    else $error("Counter write lost");
  chk_enable_hidden: assert property (
    s_statRd |=> busRdData[13:3] == 11'h000)
    else $error("Status shows enable bits");
  chk_field_mask: assert property (
    hit && busRead && busRegAddr[11] && !busRegAddr[0]
    |=> (busRdData & 16'h3180) == 16'h0000)
    else $error("Unused bits read back set");
  // Runmode low first, so no compare can set the flag again
  chk_done_clear: assert property (
    !runMode [*2] ##0 s_statRd ##1 s_statRd |=> !busRdData[15])
    else $error("Done flag not cleared");
  chk_halt_run: assert property (
    engineHalted && !(hit && busWrite && busRegAddr == 12'h001)
    |=> $stable(pcOut))
    else $error("Counter moved while halted");
endmodule // decision_engine_monitor

bind decision_engine decision_engine_monitor mon (
  .clk(clk), .nrst(nrst), .runMode(runMode), .busSel(busSel),
  .busProcAddr(busProcAddr), .busRegAddr(busRegAddr),
  .busWrite(busWrite), .busRead(busRead), .busWrData(busWrData),
  .busRdData(busRdData), .busRdValid(busRdValid), .pcOut(pcOut),
  .engineHalted(engineHalted)
);

// File: verification/host_bus_model.sv
// Control processor and host model on the system bus
`timescale 1ns/1ps
module host_bus_model
  import decision_engine_pkg::*;
(
  input wire logic clk,
  output logic busSel,
  output logic [3:0] busProcAddr,
  output logic [11:0] busRegAddr,
  output logic busWrite,
  output logic busRead,
  output decision_engine_pkg::word16_t busWrData,
  input wire decision_engine_pkg::word16_t busRdData,
  input wire logic busRdValid
);
  initial
  begin
    busProcAddr = 4'h0;
    busRegAddr = 12'h000;
    busWrData = 16'h0000;
    idle();
  end
  // One access per edge; fields go as two separate writes
  task automatic put(input logic [11:0] a, input word16_t d,
    input logic [3:0] pa, input logic w);
    busSel = 1'b1;
    busProcAddr = pa;
    busRegAddr = a;
    busWrData = d;
    busWrite = w;
    busRead = !w;
    @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [11:0] a, output word16_t q,
    output logic v);
    put(a, ~busWrData, 4'h2, 1'b0);
    q = busRdData;
    v = busRdValid;
  endtask
  // Released lines flip so stale values never look valid
  task automatic idle();
    busSel = 1'b0;
    busWrite = 1'b0;
    busRead = 1'b0;
    busRegAddr = ~busRegAddr;
    busWrData = ~busWrData;
  endtask
endmodule // host_bus_model

// File: verification/decision_engine_tb.sv
// Self-checking bench for the decision engine
`timescale 1ns/1ps
module decision_engine_tb;
  import decision_engine_pkg::*;
  typedef struct {logic [11:0] a; word16_t d; word16_t e;} row_t;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic runMode = 1'b0;
  logic busSel, busWrite, busRead, busRdValid, engineHalted, v;
  logic illegalWord;
  logic [6:0] idxSel = 7'h00;
  word16_t memData = 16'h0040;
  word16_t idxWord;
  // Immediate, compare-modify, load with move, illegal pair, guarded move
  logic [27:0] prog [10] = '{
    28'h820_C002, 28'h821_0050, 28'h822_8002, 28'h823_0003,
    28'h824_0602, 28'h825_E309, 28'h826_0800, 28'h827_0D00,
    28'h828_0009, 28'h829_D591};
  logic [3:0] busProcAddr;
  logic [11:0] busRegAddr;
  logic [9:0] pcOut;
  word16_t busWrData, busRdData, q;
  int errors = 0;
  int checks = 0;
  row_t rows [5] = '{
    '{12'h801, 16'hFFFF, 16'hFFFF},
    '{12'h800, 16'hFFFF, 16'hCE7F},
    '{12'hFFF, 16'hA5A5, 16'hA5A5},
    '{12'h002, 16'h1234, 16'h0000},
    '{12'h000, 16'hC000, 16'h0000}};
  always #20 clk = ~clk;
  decision_engine dut (
    .clk(clk), .nrst(nrst), .runMode(runMode), .busSel(busSel),
    .busProcAddr(busProcAddr), .busRegAddr(busRegAddr),
    .busWrite(busWrite), .busRead(busRead), .busWrData(busWrData),
    .busRdData(busRdData), .busRdValid(busRdValid),
    .dataMemIn(memData), .idxAddr(idxSel), .idxData(idxWord),
    .pcOut(pcOut), .engineHalted(engineHalted),
    .illegalWord(illegalWord)
  );
  host_bus_model host (
    .clk(clk), .busSel(busSel), .busProcAddr(busProcAddr),
    .busRegAddr(busRegAddr), .busWrite(busWrite), .busRead(busRead),
    .busWrData(busWrData), .busRdData(busRdData),
    .busRdValid(busRdValid)
  );
  task automatic cmp(input word16_t got, input word16_t exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #400000;
    errors++;
    conclude();
  end
  initial
  begin
    repeat (5) @(posedge clk);
    #1;
    nrst = 1'b1;
    foreach (rows[i])
    begin
      host.put(rows[i].a, rows[i].d, 4'h2, 1'b1);
      host.rd(rows[i].a, q, v);
      cmp(q, rows[i].e);
    end
    host.put(12'h801, 16'h0000, 4'h3, 1'b1);
    host.rd(12'h801, q, v);
    cmp(q, 16'hFFFF);
    cmp({15'h0000, v}, 16'h0001);
    host.put(12'h800, 16'h4000, 4'h2, 1'b1);
    host.put(12'h801, 16'h0000, 4'h2, 1'b1);
    host.idle();
    // Result flag is clear after reset, so enable bit 14 halts at once
    runMode = 1'b1;
    #1;
    cmp({15'h0000, engineHalted}, 16'h0001);
    host.put(12'h001, 16'h0155, 4'h2, 1'b1);
    cmp({6'h00, pcOut}, 16'h0155);
    host.put(12'h000, 16'h0000, 4'h2, 1'b1);
    host.put(12'h001, 16'h0000, 4'h2, 1'b1);
    cmp({6'h00, pcOut}, 16'h0000);
    host.idle();
    repeat (3) @(posedge clk);
    #1;
    runMode = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    host.rd(12'h000, q, v);
    cmp({15'h0000, q[15]}, 16'h0001);
    host.rd(12'h000, q, v);
    cmp({15'h0000, q[15]}, 16'h0000);
    host.idle();
    foreach (prog[i])
    begin
      host.put(prog[i][27:16], prog[i][15:0], 4'h2, 1'b1);
    end
    host.put(12'h001, 16'h0010, 4'h2, 1'b1);
    host.idle();
    runMode = 1'b1;
    // Stop inside the pause of the illegal word so its count is readable
    for (int i = 0; i < 40 && !illegalWord; i++)
    begin
      @(posedge clk);
      #1;
    end
    runMode = 1'b0;
    cmp({15'h0000, illegalWord}, 16'h0001);
    host.rd(12'h000, q, v);
    cmp(q, 16'hC004);
    host.idle();
    idxSel = 7'h09;
    @(posedge clk);
    #1;
    cmp(idxWord, 16'h0053);
    idxSel = 7'h11;
    runMode = 1'b1;
    for (int i = 0; i < 40 && pcOut != 10'h015; i++)
    begin
      @(posedge clk);
      #1;
    end
    runMode = 1'b0;
    cmp({6'h00, pcOut}, 16'h0015);
    cmp({15'h0000, illegalWord}, 16'h0000);
    @(posedge clk);
    #1;
    cmp(idxWord, 16'h0053);
    conclude();
  end
endmodule // decision_engine_tb
